/* design/term_cfg_pkg.sv */
// Offsets, field positions, reset values and timing constants of the terminal config bank
package term_cfg_pkg;
  // Register indices; byte address is four times the index
  localparam logic [3:0] CFG_FOUR_IDX      = 4'h8;
  localparam logic [3:0] CFG_FIVE_IDX      = 4'h9;
  localparam logic [3:0] DATA_STACK_IDX    = 4'ha;
  localparam logic [3:0] LAST_CMD_IDX      = 4'hd;
  localparam int         ADDR_W            = 6;

  // Configuration four fields
  localparam int BIT_SRC_POS       = 15;
  localparam int BIT_BUSY_POS      = 14;
  localparam int MODE_BUSY_POS     = 13;
  localparam int EXP_CTRL_POS      = 12;
  localparam int LATCH_EN_POS      = 3;
  localparam logic [2:0] LOOP_START = 3'h2;
  localparam logic [2:0] LOOP_STOP  = 3'h0;
  localparam logic [15:0] CFG_FOUR_MASK = 16'hf00f;

  // Configuration five fields
  localparam int SPARE_POS         = 15;
  localparam int INH_A_POS         = 13;
  localparam int INH_B_POS         = 12;
  localparam int ZX_POS            = 11;
  localparam int TMO_LO            = 9;
  localparam int DEADBUS_POS       = 8;
  localparam int BCAST_DIS_POS     = 7;
  localparam int LATCH_IN_POS      = 6;
  localparam logic [1:0] TMO_RESET = 2'h0;

  localparam logic [15:0] CFG_FOUR_RESET = 16'h0000;
  localparam logic [15:0] LAST_CMD_RESET = 16'h0000;
  localparam logic [15:0] SHARED_BIT_LOC = 16'h0123;
  localparam logic [4:0]  BCAST_ADDR     = 5'h1f;

  // Timing, in nanoseconds, and the clock
  localparam int CLK_NS         = 50;
  localparam int TMO0_NS        = 18500;
  localparam int TMO1_NS        = 22500;
  localparam int TMO2_NS        = 53500;
  localparam int TMO3_NS        = 130000;
  localparam int RESP_DELAY_NS  = 7000;
  localparam int TMO0_CYC       = TMO0_NS / CLK_NS;
  localparam int TMO1_CYC       = TMO1_NS / CLK_NS;
  localparam int TMO2_CYC       = TMO2_NS / CLK_NS;
  localparam int TMO3_CYC       = TMO3_NS / CLK_NS;
  localparam int RESP_DELAY_CYC = RESP_DELAY_NS / CLK_NS;
  localparam int CNT_W          = 12;
endpackage

/* design/terminal_config_address_regs.sv */
// Host register bank for terminal configuration, address latching and last command
// Functional notes
// - Config four bit 15 picks internal BIT register or shared word 0x0123.
// - While busy, never send a BIT word, regardless of bit 14.
// - While busy, never send a mode data word, regardless of bit 13.
// - Config four bit 12 selects expanded control word, bus controller only.
// - Config four bit 3 enables address latching on config five writes.
// - Writing 010 to config four bits 2..0 starts loopback; zero stops it.
// - Config five bit 15 is read/write and has no effect.
// - Config five bit 14 always reads zero.
// - Config five bits 13,12 read the bus A and B inhibit inputs.
// - Config five bit 11 always reads one.
// - Config five bits 10..9 select 18.5/22.5/53.5/130 us timeout; reset 00.
// - Terminal status response delay is fixed near 7 us.
// - Dead-bus gap of 2 us is never checked, even with bit 8 set.
// - Config five bit 7 clear makes address 31 broadcast; set makes it ordinary.
// - Bit 6 reads latch input; while low address follows the lines.
// - Latch input rising outside reset captures address lines and parity.
// - Latch high and bit 3 set: config five write latches selected source.
// - Config five bits 5..1 read address in use, bit 0 its parity.
// - Monitor data stack pointer always reads zero.
// - Last command holds 16-bit command, updated with start flag, resets zero.
// - Transmit-last-command mode command never becomes the stored last command.
// - Terminal stacks only legal commands; monitor stacks every command.
// - Internal source sends the internal BIT register content.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
module terminal_config_address_regs #(
  parameter int DATA_W = 16
) (
  input  wire logic              sys_clk_in,
  input  wire logic              reset_in,
  input  wire logic              clk_en_in,
  // Avalon-MM slave, word addressed by byte address
  input  wire logic [7:0]        avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic [31:0]            avs_readdata_out,
  output logic                   avs_waitrequest_out,
  output logic [1:0]             avs_response_out,
  // Pins
  input  wire logic              inhibit_a_in,
  input  wire logic              inhibit_b_in,
  input  wire logic              address_latch_input_in,
  input  wire logic [4:0]        terminal_address_lines_in,
  input  wire logic              terminal_address_parity_line_in,
  // Alternate latch source, chosen by config six bit 5 outside this block
  input  wire logic              alt_addr_sel_in,
  input  wire logic [5:0]        alt_addr_in,
  // Engine side
  input  wire logic              busy_in,
  input  wire logic              bc_mode_in,
  input  wire logic              monitor_mode_in,
  input  wire logic [DATA_W-1:0] internal_bit_word_in,
  input  wire logic [DATA_W-1:0] shared_bit_word_in,
  input  wire logic              message_start_flag_in,
  input  wire logic [DATA_W-1:0] command_word_in,
  input  wire logic              command_tx_last_in,
  input  wire logic              command_legal_in,
  input  wire logic              resp_wait_start_in,
  output logic [DATA_W-1:0]      bit_word_out,
  output logic [15:0]            bit_word_loc_out,
  output logic                   bit_word_send_ok_out,
  output logic                   mode_data_send_ok_out,
  output logic                   expanded_ctrl_out,
  output logic                   loopback_run_out,
  output logic [4:0]             terminal_address_out,
  output logic                   terminal_parity_out,
  output logic                   broadcast_31_out,
  output logic                   deadbus_check_out,
  output logic                   stack_push_out,
  output logic                   no_response_tmo_out,
  output logic                   status_resp_due_out
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ANS  = 2'b01
  } bus_state_t;

  typedef struct packed {
    bus_state_t       st;
    logic [31:0]      rdata;
    logic [1:0]       resp;
    logic [15:0]      cfg4;
    logic             spare;
    logic [1:0]       tmo_sel;
    logic             deadbus_req;
    logic             bcast_dis;
    logic [5:0]       addr;
    logic             latch_prev;
    logic [DATA_W-1:0] last_cmd;
    logic             tmo_run;
    logic [term_cfg_pkg::CNT_W-1:0] tmo_cnt;
    logic             tmo_hit;
    logic             resp_run;
    logic [term_cfg_pkg::CNT_W-1:0] resp_cnt;
    logic             resp_hit;
    logic             push;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic [3:0]  reg_idx;
  logic        addr_ok;
  logic [15:0] cfg5_view;
  logic [term_cfg_pkg::CNT_W-1:0] tmo_limit;

  assign reg_idx = avs_address_in[5:2];
  assign addr_ok = (avs_address_in[1:0] == 2'h0) && (avs_address_in[7:6] == 2'h0);

  always_comb begin
    case (s_r.tmo_sel)
      2'h0: tmo_limit = term_cfg_pkg::CNT_W'(term_cfg_pkg::TMO0_CYC);
      2'h1: tmo_limit = term_cfg_pkg::CNT_W'(term_cfg_pkg::TMO1_CYC);
      2'h2: tmo_limit = term_cfg_pkg::CNT_W'(term_cfg_pkg::TMO2_CYC);
      default: tmo_limit = term_cfg_pkg::CNT_W'(term_cfg_pkg::TMO3_CYC);
    endcase
  end

  always_comb begin
    cfg5_view = 16'h0000;
    cfg5_view[term_cfg_pkg::SPARE_POS]      = s_r.spare;
    cfg5_view[term_cfg_pkg::INH_A_POS]      = inhibit_a_in;
    cfg5_view[term_cfg_pkg::INH_B_POS]      = inhibit_b_in;
    cfg5_view[term_cfg_pkg::ZX_POS]         = 1'b1;
    cfg5_view[term_cfg_pkg::TMO_LO+1 -: 2]  = s_r.tmo_sel;
    cfg5_view[term_cfg_pkg::DEADBUS_POS]    = s_r.deadbus_req;
    cfg5_view[term_cfg_pkg::BCAST_DIS_POS]  = s_r.bcast_dis;
    cfg5_view[term_cfg_pkg::LATCH_IN_POS]   = address_latch_input_in;
    cfg5_view[5:0] = {terminal_address_out, terminal_parity_out};
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.push = 1'b0;
    s_nxt.tmo_hit = 1'b0;
    s_nxt.resp_hit = 1'b0;
    s_nxt.latch_prev = address_latch_input_in;
    // Lines followed while latch input is low
    if (!address_latch_input_in) begin
      s_nxt.addr = {terminal_address_lines_in, terminal_address_parity_line_in};
    end else if (!s_r.latch_prev) begin
      s_nxt.addr = {terminal_address_lines_in, terminal_address_parity_line_in};
    end
    case (s_r.st)
      ST_IDLE: begin
        if (avs_read_in || avs_write_in) begin
          s_nxt.st = ST_ANS;
          s_nxt.rdata = 32'h0000_0000;
          s_nxt.resp = addr_ok ? 2'h0 : 2'h3;
          if (avs_read_in && addr_ok) begin
            case (reg_idx)
              term_cfg_pkg::CFG_FOUR_IDX:   s_nxt.rdata[15:0] = s_r.cfg4;
              term_cfg_pkg::CFG_FIVE_IDX:   s_nxt.rdata[15:0] = cfg5_view;
              term_cfg_pkg::DATA_STACK_IDX: s_nxt.rdata[15:0] = 16'h0000;
              term_cfg_pkg::LAST_CMD_IDX:   s_nxt.rdata[15:0] = s_r.last_cmd;
              default:                      s_nxt.resp = 2'h3;
            endcase
          end
          if (avs_write_in && addr_ok && (avs_byteenable_in[1:0] == 2'h3)) begin
            case (reg_idx)
              term_cfg_pkg::CFG_FOUR_IDX: begin
                s_nxt.cfg4 = avs_writedata_in[15:0] & term_cfg_pkg::CFG_FOUR_MASK;
              end
              term_cfg_pkg::CFG_FIVE_IDX: begin
                s_nxt.spare       = avs_writedata_in[term_cfg_pkg::SPARE_POS];
                s_nxt.tmo_sel     = avs_writedata_in[term_cfg_pkg::TMO_LO+1 -: 2];
                s_nxt.deadbus_req = avs_writedata_in[term_cfg_pkg::DEADBUS_POS];
                s_nxt.bcast_dis   = avs_writedata_in[term_cfg_pkg::BCAST_DIS_POS];
                if (address_latch_input_in && s_r.latch_prev
                    && s_r.cfg4[term_cfg_pkg::LATCH_EN_POS]) begin
                  s_nxt.addr = alt_addr_sel_in ? alt_addr_in
                               : {terminal_address_lines_in, terminal_address_parity_line_in};
                end
              end
              default: begin
                s_nxt.resp = (reg_idx == term_cfg_pkg::DATA_STACK_IDX
                              || reg_idx == term_cfg_pkg::LAST_CMD_IDX) ? 2'h0 : 2'h3;
              end
            endcase
          end
        end
      end
      ST_ANS:  s_nxt.st = ST_IDLE;
      default: s_nxt.st = ST_IDLE;
    endcase
    // Last command capture with start flag; stack push policy
    if (message_start_flag_in) begin
      if (!command_tx_last_in) begin
        s_nxt.last_cmd = command_word_in;
      end
      s_nxt.push = monitor_mode_in || command_legal_in;
    end
    // Counters run on the core clock only
    if (resp_wait_start_in) begin
      s_nxt.tmo_run = 1'b1;
      s_nxt.tmo_cnt = '0;
      s_nxt.resp_run = 1'b1;
      s_nxt.resp_cnt = '0;
    end else begin
      if (s_r.tmo_run) begin
        if (s_r.tmo_cnt == tmo_limit - 1'b1) begin
          s_nxt.tmo_run = 1'b0;
          s_nxt.tmo_hit = 1'b1;
        end else begin
          s_nxt.tmo_cnt = s_r.tmo_cnt + 1'b1;
        end
      end
      if (s_r.resp_run) begin
        if (s_r.resp_cnt == term_cfg_pkg::CNT_W'(term_cfg_pkg::RESP_DELAY_CYC - 1)) begin
          s_nxt.resp_run = 1'b0;
          s_nxt.resp_hit = 1'b1;
        end else begin
          s_nxt.resp_cnt = s_r.resp_cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.cfg4 <= term_cfg_pkg::CFG_FOUR_RESET;
      s_r.tmo_sel <= term_cfg_pkg::TMO_RESET;
      s_r.last_cmd <= term_cfg_pkg::LAST_CMD_RESET;
      s_r.latch_prev <= 1'b1;
    end else if (clk_en_in) begin
      s_r <= s_nxt;
    end
  end

  // Answer cycle: waitrequest drops once the answer is registered
  assign avs_waitrequest_out = (s_r.st != ST_ANS);
  assign avs_readdata_out    = s_r.rdata;
  assign avs_response_out    = s_r.resp;

  // Host word replaces the internal register when bit 15 is set
  assign bit_word_out = s_r.cfg4[term_cfg_pkg::BIT_SRC_POS]
                        ? shared_bit_word_in : internal_bit_word_in;
  assign bit_word_loc_out = s_r.cfg4[term_cfg_pkg::BIT_SRC_POS]
                            ? term_cfg_pkg::SHARED_BIT_LOC : 16'h0000;
  assign bit_word_send_ok_out  = !busy_in;
  assign mode_data_send_ok_out = !busy_in;
  assign expanded_ctrl_out = bc_mode_in && s_r.cfg4[term_cfg_pkg::EXP_CTRL_POS];
  assign loopback_run_out  = (s_r.cfg4[2:0] == term_cfg_pkg::LOOP_START);
  assign terminal_address_out = s_r.addr[5:1];
  assign terminal_parity_out  = s_r.addr[0];
  assign broadcast_31_out  = !s_r.bcast_dis;
  assign deadbus_check_out = 1'b0;
  assign stack_push_out = s_r.push;
  assign no_response_tmo_out = s_r.tmo_hit;
  assign status_resp_due_out = s_r.resp_hit;

  // Bus answer checks
  rd_hi_zero_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !avs_waitrequest_out |-> avs_readdata_out[31:16] == 16'h0000)
    else $error("upper read half not zero");
  wait_ans_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (clk_en_in && !avs_waitrequest_out) |=> avs_waitrequest_out)
    else $error("answer longer than one cycle");
  cfg5_const_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (s_r.st == ST_ANS && $past(avs_read_in) && $past(addr_ok)
      && $past(reg_idx) == term_cfg_pkg::CFG_FIVE_IDX) |-> s_r.rdata[11] && !s_r.rdata[14])
    else $error("fixed config five bits wrong");

  // Send gating checks
  bit_int_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !s_r.cfg4[term_cfg_pkg::BIT_SRC_POS] |-> bit_word_out == internal_bit_word_in)
    else $error("internal BIT word not sent");
  bit_shared_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    s_r.cfg4[term_cfg_pkg::BIT_SRC_POS] |-> bit_word_out == shared_bit_word_in)
    else $error("host BIT word not sent");
  mode_busy_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    busy_in |-> !mode_data_send_ok_out)
    else $error("mode data allowed while busy");
  exp_ctrl_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !bc_mode_in |-> !expanded_ctrl_out)
    else $error("expanded control outside controller mode");
  bcast_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    s_r.bcast_dis |-> !broadcast_31_out)
    else $error("address 31 still broadcast");

  // Address and command capture checks
  latch_edge_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (clk_en_in && address_latch_input_in && !s_r.latch_prev) |=> {terminal_address_out,
      terminal_parity_out} == $past({terminal_address_lines_in, terminal_address_parity_line_in}))
    else $error("address not captured on latch edge");
  tx_last_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (clk_en_in && message_start_flag_in && command_tx_last_in) |=> $stable(s_r.last_cmd))
    else $error("transmit last command was stored");
  push_mon_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (clk_en_in && message_start_flag_in && monitor_mode_in) |=> stack_push_out)
    else $error("monitor command not stacked");
  push_bad_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (clk_en_in && message_start_flag_in && !monitor_mode_in && !command_legal_in)
      |=> !stack_push_out)
    else $error("illegal command stacked");

  // Counter checks
  resp_len_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (clk_en_in && resp_wait_start_in) |=> !status_resp_due_out [*8])
    else $error("status response too early");
  tmo_pulse_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (clk_en_in && no_response_tmo_out) |=> !no_response_tmo_out)
    else $error("timeout pulse too long");

  bit_src_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    s_r.cfg4[15] |-> bit_word_loc_out == 16'h0123)
    else $error("BIT word location wrong");
  busy_bit_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    busy_in |-> !bit_word_send_ok_out && !mode_data_send_ok_out)
    else $error("word sent while busy");
  zero_read_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (s_r.st == ST_ANS && $past(reg_idx) == 4'ha && $past(avs_read_in)) |-> s_r.rdata == 0)
    else $error("stack pointer not zero");
  deadbus_off_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    s_r.deadbus_req |-> !deadbus_check_out)
    else $error("dead bus checked");
  last_cmd_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (clk_en_in && message_start_flag_in && !command_tx_last_in)
      |=> s_r.last_cmd == $past(command_word_in))
    else $error("last command not captured");
  addr_follow_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (clk_en_in && !address_latch_input_in)
      |=> terminal_address_out == $past(terminal_address_lines_in))
    else $error("address not following lines");
  tmo_len_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (clk_en_in && resp_wait_start_in && s_r.tmo_sel == 2'h0 && !s_r.tmo_run)
      |=> !no_response_tmo_out [*8])
    else $error("timeout too early");
  loop_start_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (clk_en_in && s_r.st == ST_IDLE && avs_write_in && addr_ok && avs_byteenable_in[1:0] == 2'h3
      && reg_idx == term_cfg_pkg::CFG_FOUR_IDX
      && avs_writedata_in[2:0] == term_cfg_pkg::LOOP_START) |=> loopback_run_out)
    else $error("loopback not started");
  loop_stop_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (clk_en_in && s_r.st == ST_IDLE && avs_write_in && addr_ok && avs_byteenable_in[1:0] == 2'h3
      && reg_idx == term_cfg_pkg::CFG_FOUR_IDX
      && avs_writedata_in[2:0] == term_cfg_pkg::LOOP_STOP) |=> !loopback_run_out)
    else $error("loopback not stopped");

endmodule

/* test/host_bus_model.sv */
// Avalon-MM host model that issues single register accesses
module host_bus_model (
  input  wire logic        clk_in,
  input  wire logic        waitrequest_in,
  input  wire logic [31:0] readdata_in,
  input  wire logic [1:0]  response_in,
  output logic [7:0]       address_out,
  output logic             read_out,
  output logic             write_out,
  output logic [31:0]      writedata_out,
  output logic [3:0]       byteenable_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    address_out = 8'h00;
    read_out = 1'b0;
    write_out = 1'b0;
    writedata_out = 32'h00000000;
    byteenable_out = 4'hf;
  end
  // Request held until waitrequest is sampled low on a rising edge; bench watchdog ends hangs
  task automatic access(input logic we, input logic [7:0] a, input logic [15:0] d,
                        output logic [31:0] q, output logic [1:0] rsp);
    @(posedge clk_in);
    address_out <= a;
    read_out <= !we;
    write_out <= we;
    writedata_out <= {16'h0000, d};
    do begin
      @(posedge clk_in);
    end while (waitrequest_in !== 1'b0);
    q = readdata_in;
    rsp = response_in;
    read_out <= 1'b0;
    write_out <= 1'b0;
    // Stale data is not left on the bus
    writedata_out <= ~writedata_out;
  endtask
endmodule

/* test/tb_top.sv */
// Self-checking bench for the terminal config register bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic we; logic [7:0] a; logic [15:0] d; logic [15:0] e;} row_t;
  logic        sys_clk_in = 1'b0, reset_in = 1'b1, clk_en_in = 1'b1;
  logic [7:0]  avs_address_in;
  logic        avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [31:0] avs_writedata_in, avs_readdata_out, rq;
  logic [3:0]  avs_byteenable_in;
  logic [1:0]  avs_response_out, rr;
  logic        inhibit_a_in = 1'b1, inhibit_b_in = 1'b0, address_latch_input_in = 1'b0;
  logic [4:0]  terminal_address_lines_in = 5'h15, terminal_address_out;
  logic        terminal_address_parity_line_in = 1'b1, alt_addr_sel_in = 1'b0;
  logic [5:0]  alt_addr_in = 6'h2c;
  logic        busy_in = 1'b0, bc_mode_in = 1'b0, monitor_mode_in = 1'b0;
  logic        message_start_flag_in = 1'b0, command_tx_last_in = 1'b0;
  logic        command_legal_in = 1'b1, resp_wait_start_in = 1'b0;
  logic [15:0] internal_bit_word_in = 16'h5a3c, shared_bit_word_in = 16'ha5c3;
  logic [15:0] command_word_in = 16'h0000, bit_word_out, bit_word_loc_out;
  logic        bit_word_send_ok_out, mode_data_send_ok_out, expanded_ctrl_out;
  logic        loopback_run_out, terminal_parity_out, broadcast_31_out, deadbus_check_out;
  logic        stack_push_out, no_response_tmo_out, status_resp_due_out;
  int          errors = 0, checks = 0;
  row_t rows[12] = '{
    '{1'b0, 8'h20, 16'h0000, 16'h0000},
    '{1'b0, 8'h24, 16'h0000, 16'h282b},
    '{1'b0, 8'h28, 16'h0000, 16'h0000},
    '{1'b0, 8'h34, 16'h0000, 16'h0000},
    '{1'b1, 8'h20, 16'hffff, 16'h0000},
    '{1'b0, 8'h20, 16'h0000, 16'hf00f},
    '{1'b1, 8'h24, 16'h8680, 16'h0000},
    '{1'b0, 8'h24, 16'h0000, 16'haeab},
    '{1'b1, 8'h28, 16'hffff, 16'h0000},
    '{1'b0, 8'h28, 16'h0000, 16'h0000},
    '{1'b1, 8'h34, 16'hffff, 16'h0000},
    '{1'b0, 8'h34, 16'h0000, 16'h0000}};
  always #25 sys_clk_in = ~sys_clk_in;
  host_bus_model host_bus_model_i (.clk_in(sys_clk_in), .waitrequest_in(avs_waitrequest_out),
    .readdata_in(avs_readdata_out), .response_in(avs_response_out),
    .address_out(avs_address_in), .read_out(avs_read_in), .write_out(avs_write_in),
    .writedata_out(avs_writedata_in), .byteenable_out(avs_byteenable_in));
  terminal_config_address_regs terminal_config_address_regs_i (.sys_clk_in, .reset_in,
    .clk_en_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .avs_response_out,
    .inhibit_a_in, .inhibit_b_in, .address_latch_input_in, .terminal_address_lines_in,
    .terminal_address_parity_line_in, .alt_addr_sel_in, .alt_addr_in, .busy_in, .bc_mode_in,
    .monitor_mode_in, .internal_bit_word_in, .shared_bit_word_in, .message_start_flag_in,
    .command_word_in, .command_tx_last_in, .command_legal_in, .resp_wait_start_in,
    .bit_word_out, .bit_word_loc_out, .bit_word_send_ok_out, .mode_data_send_ok_out,
    .expanded_ctrl_out, .loopback_run_out, .terminal_address_out, .terminal_parity_out,
    .broadcast_31_out, .deadbus_check_out, .stack_push_out, .no_response_tmo_out,
    .status_resp_due_out);
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    host_bus_model_i.access(1'b0, a, 16'h0000, rq, rr);
    cmp(rq, {16'h0000, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host_bus_model_i.access(1'b1, a, d, rq, rr);
  endtask
  task automatic message_start_flag(input logic [15:0] c, input logic tl, input logic lg, input logic p);
    @(posedge sys_clk_in);
    command_word_in <= c;
    command_tx_last_in <= tl;
    command_legal_in <= lg;
    message_start_flag_in <= 1'b1;
    @(posedge sys_clk_in);
    message_start_flag_in <= 1'b0;
    @(negedge sys_clk_in);
    cmp(stack_push_out, p);
  endtask
  // First sample falls half a cycle after the start pulse is taken
  task automatic tmo_run(input logic [1:0] code, input int ec);
    int n, gt, gr;
    gt = 0;
    gr = 0;
    wr(8'h24, {5'h00, code, 9'h000});
    @(posedge sys_clk_in);
    resp_wait_start_in <= 1'b1;
    @(posedge sys_clk_in);
    resp_wait_start_in <= 1'b0;
    for (n = 1; n <= ec + 10; n++) begin
      @(negedge sys_clk_in);
      if (no_response_tmo_out === 1'b1 && gt == 0) gt = n;
      if (status_resp_due_out === 1'b1 && gr == 0) gr = n;
    end
    cmp(gt, ec + 1);
    cmp(gr, 141);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    errors++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].we) wr(rows[i].a, rows[i].d);
      else rd(rows[i].a, rows[i].e);
    end
    $display("register table done");
    @(negedge sys_clk_in);
    cmp(bit_word_loc_out, 16'h0123);
    cmp(bit_word_out, 16'ha5c3);
    cmp(broadcast_31_out, 1'b0);
    cmp(expanded_ctrl_out, 1'b0);
    @(posedge sys_clk_in);
    bc_mode_in <= 1'b1;
    busy_in <= 1'b1;
    @(negedge sys_clk_in);
    cmp(expanded_ctrl_out, 1'b1);
    cmp(bit_word_send_ok_out, 1'b0);
    cmp(mode_data_send_ok_out, 1'b0);
    $display("busy and mode test done");
    wr(8'h20, 16'h0002);
    cmp(loopback_run_out, 1'b1);
    cmp(bit_word_loc_out, 16'h0000);
    cmp(bit_word_out, 16'h5a3c);
    wr(8'h20, 16'h0000);
    cmp(loopback_run_out, 1'b0);
    wr(8'h24, 16'h0100);
    cmp(deadbus_check_out, 1'b0);
    cmp(broadcast_31_out, 1'b1);
    rd(8'h2c, 16'h0000);
    cmp(rr, 2'h3);
    wr(8'h21, 16'hffff);
    cmp(rr, 2'h3);
    rd(8'h20, 16'h0000);
    $display("loopback and refusal test done");
    @(posedge sys_clk_in);
    address_latch_input_in <= 1'b1;
    @(posedge sys_clk_in);
    terminal_address_lines_in <= 5'h0a;
    terminal_address_parity_line_in <= 1'b0;
    wr(8'h24, 16'h0000);
    cmp({terminal_address_out, terminal_parity_out}, 6'h2b);
    rd(8'h24, 16'h286b);
    wr(8'h20, 16'h0008);
    alt_addr_sel_in <= 1'b1;
    wr(8'h24, 16'h0000);
    cmp({terminal_address_out, terminal_parity_out}, 6'h2c);
    alt_addr_sel_in <= 1'b0;
    address_latch_input_in <= 1'b0;
    repeat (3) @(negedge sys_clk_in);
    cmp({terminal_address_out, terminal_parity_out}, 6'h14);
    $display("address latch test done");
    message_start_flag(16'h1234, 1'b0, 1'b1, 1'b1);
    rd(8'h34, 16'h1234);
    message_start_flag(16'h0c12, 1'b1, 1'b1, 1'b1);
    rd(8'h34, 16'h1234);
    message_start_flag(16'h0777, 1'b0, 1'b0, 1'b0);
    monitor_mode_in <= 1'b1;
    message_start_flag(16'h0777, 1'b0, 1'b0, 1'b1);
    monitor_mode_in <= 1'b0;
    $display("last command test done");
    tmo_run(2'h0, 370);
    tmo_run(2'h1, 450);
    tmo_run(2'h2, 1070);
    tmo_run(2'h3, 2600);
    $display("timeout test done");
    @(posedge sys_clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    rd(8'h24, 16'h2814);
    rd(8'h34, 16'h0000);
    $display("second reset test done");
    summarize();
  end
endmodule
